// file: core/lcam_top.sv
// Load current alarm monitor: APB registers, sampling, three alarms, interrupt.
// Assumes a CT sample word with a strobe, and output states of the heat outputs.
// Function
// - Sample load when on, leakage when off
// - Enable bit, default off, gates everything; here a pending interrupt status keeps irq asserted while off
// - Full scale up to 1000, default 100.0
// - Latch type: none, auto, manual
// - Low threshold zero means off
// - Low load alarm below threshold
// - Leakage threshold zero off, high limit
// - Leakage alarm when off-state current exceeds
// - Over-current threshold zero off, high limit
// - Over-current alarm when current exceeds threshold
// - Ack write one clears all alarms; here only latched alarms whose condition has ended
// - Release needs hysteresis of 0..5 percent
//
// Decided for this implementation: the APB interface to the registers and the address map.
`default_nettype none
module lcam_top import lcam_pkg::*; (
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Transformer sample and heat outputs
	input wire logic [13:0] ct_sample,
	input wire logic ct_valid,
	input wire logic [3:0] output_on,
	// Alarms and interrupt
	output logic low_load_alarm,
	output logic leakage_alarm,
	output logic overcurrent_alarm,
	output logic irq
);
	// Configuration state
	logic monitor_enable_q;
	logic [2:0] monitored_output_select_q;
	logic [1:0] alarm_latch_type_q;
	logic [13:0] transformer_full_scale_q;
	logic [13:0] low_load_threshold_q;
	logic [13:0] leakage_threshold_q;
	logic [13:0] overcurrent_threshold_q;
	logic [2:0] hyst_pct_q;
	logic [13:0] load_current_q;
	logic [13:0] measured_leakage_current_q;
	logic [2:0] irq_stat_q;
	logic [2:0] irq_en_q;
	logic [2:0] alarm_prev_q;
	logic [2:0] alarm_w;
	logic [13:0] band;
	logic wr;
	logic rd;
	logic ack_pulse;
	logic sel_on;
	logic samp_on;
	logic samp_off;
	logic [2:0] trip;
	logic [2:0] rel;

	// Clamp a written value to a limit: the current full scale, or RANGE_MAX for the range itself
	function automatic logic [13:0] clamp_fs(input logic [31:0] v, input logic [13:0] fs);
		clamp_fs = (v > 32'(fs)) ? fs : v[13:0];
	endfunction

	// Offset is mapped when it lands on a defined register
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a[1:0] == 2'b00) && (a <= OFS_IRQ_CLR);
	endfunction

	assign wr = psel && penable && pwrite && pready;
	assign rd = psel && !penable && !pwrite;
	assign ack_pulse = wr && (paddr == OFS_ACK) && pwdata[0];

	// Zero-wait answer: ready raised in every access phase
	// No wait states, so read data reflect state at the setup edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped(paddr);
		end
	end

	// Control and select; enable default off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			monitor_enable_q <= 1'b0;
			monitored_output_select_q <= SEL_NONE;
			alarm_latch_type_q <= LCAM_LAT_NONE;
		end else if (wr && paddr == OFS_CTRL) begin
			monitor_enable_q <= pwdata[CTRL_EN_BIT];
			if (pwdata[CTRL_SEL_LSB +: 3] <= SEL_MAX) begin
				monitored_output_select_q <= pwdata[CTRL_SEL_LSB +: 3];
			end
			// Illegal latch code 3 is refused, old value kept
			if (pwdata[CTRL_LAT_LSB +: 2] != 2'h3) begin
				alarm_latch_type_q <= pwdata[CTRL_LAT_LSB +: 2];
			end
		end
	end

	// Full scale and hysteresis
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			transformer_full_scale_q <= RANGE_RST;
			hyst_pct_q <= HYST_RST;
		end else begin
			if (wr && paddr == OFS_RANGE) begin
				transformer_full_scale_q <= clamp_fs(pwdata, RANGE_MAX);
			end
			if (wr && paddr == OFS_HYST) begin
				hyst_pct_q <= (pwdata > 32'(HYST_MAX)) ? HYST_MAX : pwdata[2:0];
			end
		end
	end

	// Thresholds, zero is off, capped at full scale
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_load_threshold_q <= THR_OFF;
			leakage_threshold_q <= THR_OFF;
			overcurrent_threshold_q <= THR_OFF;
		end else if (wr) begin
			if (paddr == OFS_LOW_THR) begin
				low_load_threshold_q <= clamp_fs(pwdata, transformer_full_scale_q);
			end
			if (paddr == OFS_LEAK_THR) begin
				leakage_threshold_q <= clamp_fs(pwdata, transformer_full_scale_q);
			end
			if (paddr == OFS_OVER_THR) begin
				overcurrent_threshold_q <= clamp_fs(pwdata, transformer_full_scale_q);
			end
		end
	end

	// Pick the monitored output's state; select none never samples
	assign sel_on = (monitored_output_select_q != SEL_NONE)
		&& output_on[2'(monitored_output_select_q - 3'h1)];
	assign samp_on = monitor_enable_q && ct_valid
		&& (monitored_output_select_q != SEL_NONE) && sel_on;
	assign samp_off = monitor_enable_q && ct_valid
		&& (monitored_output_select_q != SEL_NONE) && !sel_on;

	// Readings split by output state and held between samples
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			load_current_q <= 14'h0000;
			measured_leakage_current_q <= 14'h0000;
		end else begin
			if (samp_on) begin
				load_current_q <= ct_sample;
			end
			if (samp_off) begin
				measured_leakage_current_q <= ct_sample;
			end
		end
	end

	// Trip and release terms; release uses the hysteresis band
	// Sums widened to 15 bits so threshold plus band cannot wrap
	always_comb begin
		trip = 3'b000;
		rel = 3'b000;
		if (samp_on && low_load_threshold_q != THR_OFF) begin
			trip[ALM_LOW] = ct_sample < low_load_threshold_q;
			rel[ALM_LOW] = 15'(ct_sample) >= 15'(low_load_threshold_q) + 15'(band);
		end
		if (samp_off && leakage_threshold_q != THR_OFF) begin
			trip[ALM_LEAK] = ct_sample > leakage_threshold_q;
			rel[ALM_LEAK] = 15'(ct_sample) + 15'(band) <= 15'(leakage_threshold_q);
		end
		if ((samp_on || samp_off) && overcurrent_threshold_q != THR_OFF) begin
			trip[ALM_OVER] = ct_sample > overcurrent_threshold_q;
			rel[ALM_OVER] = 15'(ct_sample) + 15'(band) <= 15'(overcurrent_threshold_q);
		end
		// A threshold switched off releases its alarm condition
		if (low_load_threshold_q == THR_OFF) rel[ALM_LOW] = 1'b1;
		if (leakage_threshold_q == THR_OFF) rel[ALM_LEAK] = 1'b1;
		if (overcurrent_threshold_q == THR_OFF) rel[ALM_OVER] = 1'b1;
	end

	lcam_hyst u_hyst (
		.pclk(pclk),
		.presetn(presetn),
		.range_i(transformer_full_scale_q),
		.pct_i(hyst_pct_q),
		.band_q(band)
	);

	// One flag unit per alarm
	// All units share ack and latch type, so one write acknowledges all
	generate
		for (genvar i = 0; i < 3; i++) begin : g_alarm
			lcam_alarm u_alarm (
				.pclk(pclk),
				.presetn(presetn),
				.enable_i(monitor_enable_q),
				.lat_i(alarm_latch_type_q),
				.ack_i(ack_pulse),
				.trip_i(trip[i]),
				.release_i(rel[i]),
				.alarm_q(alarm_w[i])
			);
		end
	endgenerate

	// Alarm outputs are the flag flops themselves
	assign low_load_alarm = alarm_w[ALM_LOW];
	assign leakage_alarm = alarm_w[ALM_LEAK];
	assign overcurrent_alarm = alarm_w[ALM_OVER];

	// Sticky status on rising alarm; set wins over clear
	// Status follows the rising edge of an alarm, not its level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_prev_q <= 3'b000;
			irq_stat_q <= 3'b000;
			irq_en_q <= 3'b000;
		end else begin
			alarm_prev_q <= alarm_w;
			irq_stat_q <= (irq_stat_q & ~((wr && paddr == OFS_IRQ_CLR) ? pwdata[2:0] : 3'b000))
				| (alarm_w & ~alarm_prev_q);
			if (wr && paddr == OFS_IRQ_EN) begin
				irq_en_q <= pwdata[2:0];
			end
		end
	end

	// Interrupt level from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat_q & irq_en_q);
		end
	end

	// Read data registered in setup phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd) begin
			unique case (paddr)
				OFS_CTRL: prdata <= {22'h0, alarm_latch_type_q, 1'b0,
					monitored_output_select_q, 3'b000, monitor_enable_q};
				OFS_RANGE: prdata <= {18'h0, transformer_full_scale_q};
				OFS_LOW_THR: prdata <= {18'h0, low_load_threshold_q};
				OFS_LEAK_THR: prdata <= {18'h0, leakage_threshold_q};
				OFS_OVER_THR: prdata <= {18'h0, overcurrent_threshold_q};
				OFS_HYST: prdata <= {29'h0, hyst_pct_q};
				OFS_ALARM: prdata <= {29'h0, alarm_w};
				OFS_LOAD_I: prdata <= {18'h0, load_current_q};
				OFS_LEAK_I: prdata <= {18'h0, measured_leakage_current_q};
				OFS_IRQ_STAT: prdata <= {29'h0, irq_stat_q};
				OFS_IRQ_EN: prdata <= {29'h0, irq_en_q};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Checks
	// Alarms and readings stay quiet while the monitor is off
	AST_DISABLED_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
		!monitor_enable_q |=> !alarm_w[0] && !alarm_w[1] && !alarm_w[2])
		else $error("alarm active while monitor disabled");
	AST_DIS_NO_READING: assert property (@(posedge pclk) disable iff (!presetn)
		!monitor_enable_q && ct_valid
		|=> $stable(load_current_q) && $stable(measured_leakage_current_q))
		else $error("reading moved while monitor disabled");

	// Each reading moves only on its own kind of sample
	AST_LOAD_SAMPLE: assert property (@(posedge pclk) disable iff (!presetn)
		samp_on |=> load_current_q == $past(ct_sample))
		else $error("load reading not captured");
	AST_LEAK_SAMPLE: assert property (@(posedge pclk) disable iff (!presetn)
		samp_off |=> measured_leakage_current_q == $past(ct_sample))
		else $error("leakage reading not captured");
	AST_LOAD_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		samp_off |=> $stable(load_current_q))
		else $error("load reading moved on an off sample");
	AST_LEAK_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		samp_on |=> $stable(measured_leakage_current_q))
		else $error("leakage reading moved on an on sample");
	AST_IDLE_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		!ct_valid |=> $stable(load_current_q) && $stable(measured_leakage_current_q))
		else $error("reading moved without a sample");
	AST_READ_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
		rd && paddr == OFS_LOAD_I |=> prdata == {18'h0, $past(load_current_q)})
		else $error("load reading not presented");
	AST_READ_LEAK: assert property (@(posedge pclk) disable iff (!presetn)
		rd && paddr == OFS_LEAK_I |=> prdata == {18'h0, $past(measured_leakage_current_q)})
		else $error("leakage reading not presented");

	// Each trip term reaches its flag two edges later
	AST_LOW_TRIP: assert property (@(posedge pclk) disable iff (!presetn)
		trip[ALM_LOW] |=> ##1 low_load_alarm)
		else $error("low load alarm missing");
	AST_LEAK_TRIP: assert property (@(posedge pclk) disable iff (!presetn)
		trip[ALM_LEAK] |=> ##1 leakage_alarm)
		else $error("leakage alarm missing");
	AST_OVER_TRIP: assert property (@(posedge pclk) disable iff (!presetn)
		trip[ALM_OVER] |=> ##1 overcurrent_alarm)
		else $error("over-current alarm missing");
	// Same from the raw sample, so a broken trip term shows up too
	AST_LOW_RAW: assert property (@(posedge pclk) disable iff (!presetn)
		samp_on && low_load_threshold_q != THR_OFF && ct_sample < low_load_threshold_q
		|=> ##1 low_load_alarm)
		else $error("low load sample did not raise the alarm");
	AST_LEAK_RAW: assert property (@(posedge pclk) disable iff (!presetn)
		samp_off && leakage_threshold_q != THR_OFF && ct_sample > leakage_threshold_q
		|=> ##1 leakage_alarm)
		else $error("leakage sample did not raise the alarm");
	AST_OVER_RAW: assert property (@(posedge pclk) disable iff (!presetn)
		monitor_enable_q && ct_valid && monitored_output_select_q != SEL_NONE
		&& overcurrent_threshold_q != THR_OFF && ct_sample > overcurrent_threshold_q
		|=> ##1 overcurrent_alarm)
		else $error("over-current sample did not raise the alarm");

	// Zero threshold never trips; settings stay inside their limits
	AST_LOW_OFF: assert property (@(posedge pclk) disable iff (!presetn)
		low_load_threshold_q == THR_OFF |-> !trip[ALM_LOW])
		else $error("off threshold tripped");
	AST_THR_LIMIT: assert property (@(posedge pclk) disable iff (!presetn)
		low_load_threshold_q <= RANGE_MAX && leakage_threshold_q <= RANGE_MAX
		&& overcurrent_threshold_q <= RANGE_MAX)
		else $error("threshold beyond full scale");
	AST_HYST_MAX: assert property (@(posedge pclk) disable iff (!presetn)
		hyst_pct_q <= HYST_MAX && transformer_full_scale_q <= RANGE_MAX)
		else $error("setting beyond limit");
	AST_LATCH_CODE: assert property (@(posedge pclk) disable iff (!presetn)
		alarm_latch_type_q != 2'h3)
		else $error("illegal latch type");

	COV_LOW: cover property (@(posedge pclk) disable iff (!presetn) $rose(low_load_alarm));
	COV_LEAK: cover property (@(posedge pclk) disable iff (!presetn) $rose(leakage_alarm));
	COV_OVER: cover property (@(posedge pclk) disable iff (!presetn) $rose(overcurrent_alarm));
	COV_IRQ: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
	COV_MAN_ACK: cover property (@(posedge pclk) disable iff (!presetn)
		ack_pulse && alarm_latch_type_q == LCAM_LAT_MAN && overcurrent_alarm);
endmodule // lcam_top
`default_nettype wire

// file: core/lcam_pkg.sv
// Package for the load current alarm monitor: register map, fields, resets.
// Assumes a 32-bit APB slave with one aligned word per register.
`default_nettype none
package lcam_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_RANGE = 8'h04;
	localparam logic [7:0] OFS_LOW_THR = 8'h08;
	localparam logic [7:0] OFS_LEAK_THR = 8'h0C;
	localparam logic [7:0] OFS_OVER_THR = 8'h10;
	localparam logic [7:0] OFS_HYST = 8'h14;
	localparam logic [7:0] OFS_ACK = 8'h18;
	localparam logic [7:0] OFS_ALARM = 8'h1C;
	localparam logic [7:0] OFS_LOAD_I = 8'h20;
	localparam logic [7:0] OFS_LEAK_I = 8'h24;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h28;
	localparam logic [7:0] OFS_IRQ_EN = 8'h2C;
	localparam logic [7:0] OFS_IRQ_CLR = 8'h30;
	// Control register fields
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_SEL_LSB = 4;
	localparam int CTRL_LAT_LSB = 8;
	// Alarm bit positions
	localparam int ALM_LOW = 0;
	localparam int ALM_LEAK = 1;
	localparam int ALM_OVER = 2;
	// Value widths and limits (current in tenths of an amp)
	localparam int VAL_W = 14;
	localparam logic [13:0] RANGE_MAX = 14'h2710;
	localparam logic [13:0] RANGE_RST = 14'h03E8;
	localparam logic [13:0] THR_OFF = 14'h0000;
	localparam logic [2:0] HYST_MAX = 3'h5;
	localparam logic [2:0] HYST_RST = 3'h2;
	localparam logic [2:0] SEL_NONE = 3'h0;
	localparam logic [2:0] SEL_MAX = 3'h4;
	// Latch modes
	typedef enum logic [1:0] {
		LCAM_LAT_NONE = 2'h0,
		LCAM_LAT_AUTO = 2'h1,
		LCAM_LAT_MAN = 2'h2
	} lcam_lat_e;
endpackage : lcam_pkg
`default_nettype wire

// file: core/lcam_hyst.sv
// Hysteresis band: percent of full scale, computed as range*pct/100.
// Assumes range and percent are already clamped to legal values.
`default_nettype none
module lcam_hyst import lcam_pkg::*; (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Settings
	input wire logic [13:0] range_i,
	input wire logic [2:0] pct_i,
	// Band result
	output logic [13:0] band_q
);
	logic [16:0] prod;
	// Registered to keep the multiplier off the compare path
	assign prod = 17'(range_i) * 17'(pct_i);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			band_q <= 14'h0000;
		end else begin
			band_q <= 14'(prod / 17'h0_0064);
		end
	end
endmodule // lcam_hyst
`default_nettype wire

// file: core/lcam_alarm.sv
// One alarm flag with hysteresis release and selectable latching.
// Assumes the condition inputs are already qualified by enable and sample.
`default_nettype none
module lcam_alarm import lcam_pkg::*; (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic enable_i,
	input wire logic [1:0] lat_i,
	input wire logic ack_i,
	// Conditions
	input wire logic trip_i,
	input wire logic release_i,
	// Result
	output logic alarm_q
);
	logic acked_q;
	logic cond_q;
	// Raw condition with hysteresis: trips on trip, clears only on release or when disabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cond_q <= 1'b0;
		end else if (!enable_i) begin
			cond_q <= 1'b0;
		end else if (trip_i) begin
			cond_q <= 1'b1;
		end else if (release_i) begin
			cond_q <= 1'b0;
		end
	end
	// Ack remembered for auto-reset latch; a new trip rearms it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acked_q <= 1'b0;
		end else if (!enable_i || !alarm_q || (trip_i && !cond_q)) begin
			acked_q <= 1'b0;
		end else if (ack_i) begin
			acked_q <= 1'b1;
		end
	end
	// Latched output per mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_q <= 1'b0;
		end else if (!enable_i) begin
			alarm_q <= 1'b0;
		end else if (cond_q) begin
			alarm_q <= 1'b1;
		end else begin
			unique case (lat_i)
				LCAM_LAT_AUTO: alarm_q <= alarm_q && !(acked_q || ack_i);
				LCAM_LAT_MAN: alarm_q <= alarm_q && !ack_i;
				default: alarm_q <= 1'b0;
			endcase
		end
	end
	// Manual latch: ack after the condition has ended clears the flag
	AST_MAN_ACK: assert property (@(posedge pclk) disable iff (!presetn)
		ack_i && lat_i == LCAM_LAT_MAN && !cond_q |=> !alarm_q)
		else $error("manual ack did not clear");
endmodule // lcam_alarm
`default_nettype wire

// file: sim/lcam_ct_model.sv
// Behavioural current transformer feeding one strobed sample per request.
// Assumes the bench raises fire for one cycle with the wanted level.
`default_nettype none
module lcam_ct_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Request from the bench
	input wire logic fire,
	input wire logic [13:0] level,
	// Sample word to the monitor
	output logic [13:0] ct_sample,
	output logic ct_valid
);
	timeunit 1ns;
	timeprecision 1ns;
	// Word means nothing without the strobe, so scramble it in between
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ct_sample <= 14'h0000;
			ct_valid <= 1'b0;
		end else begin
			ct_valid <= fire;
			ct_sample <= fire ? level : ~ct_sample;
		end
	end
endmodule // lcam_ct_model
`default_nettype wire

// file: sim/tb_top.sv
// Bench for the load current alarm monitor: APB tasks and alarm scenarios.
// Assumes lcam_top, the transformer model and one 20 MHz clock.
`default_nettype none
module tb_top import lcam_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	// Stimulus and observed signals
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, rd;
	logic pready, pslverr, irq, err, ct_valid;
	logic fire = 1'b0;
	logic [13:0] ct_sample;
	logic [13:0] level = 14'h0000;
	logic [3:0] output_on = 4'h0;
	logic low_load_alarm, leakage_alarm, overcurrent_alarm;
	int bad_count = 0;
	int total_checks = 0;
	// Clock
	always #25 pclk = ~pclk;
	// Device and far side
	lcam_top i_lcam_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ct_sample(ct_sample), .ct_valid(ct_valid), .output_on(output_on),
		.low_load_alarm(low_load_alarm), .leakage_alarm(leakage_alarm),
		.overcurrent_alarm(overcurrent_alarm), .irq(irq));
	lcam_ct_model i_lcam_ct_model (.pclk(pclk), .presetn(presetn), .fire(fire),
		.level(level), .ct_sample(ct_sample), .ct_valid(ct_valid));

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: saw %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// One APB transfer; request held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge pclk);
		end
		if (n == 20) bad_count++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		repeat (2) @(posedge pclk);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		check(rd, exp);
	endtask

	// Sample reaches the alarms two edges after the strobe is taken
	task automatic samp(input logic [13:0] v);
		level <= v;
		fire <= 1'b1;
		@(posedge pclk);
		fire <= 1'b0;
		repeat (5) @(posedge pclk);
	endtask

	task automatic alm(input logic [2:0] exp);
		check({29'h0, overcurrent_alarm, leakage_alarm, low_load_alarm}, {29'h0, exp});
	endtask

	task automatic t_reset();
		rdchk(OFS_CTRL, 32'h0000_0000);
		rdchk(OFS_RANGE, 32'h0000_03E8);
		rdchk(OFS_LOW_THR, 32'h0000_0000);
		rdchk(OFS_LEAK_THR, 32'h0000_0000);
		rdchk(OFS_OVER_THR, 32'h0000_0000);
		rdchk(OFS_HYST, 32'h0000_0002);
		rdchk(8'h34, 32'h0000_0000);
		check({31'h0, err}, 32'h0000_0001);
	endtask

	// Disabled monitor ignores samples even above a threshold
	task automatic t_disabled();
		wr(OFS_OVER_THR, 32'h0000_0320);
		wr(OFS_CTRL, 32'h0000_0010);
		output_on <= 4'h1;
		samp(14'h0384);
		alm(3'b000);
		rdchk(OFS_LOAD_I, 32'h0000_0000);
	endtask

	// Over-current trip and release past the 2% band of 1000
	task automatic t_over();
		wr(OFS_CTRL, 32'h0000_0011);
		samp(14'h0000);
		alm(3'b000);
		samp(14'h0384);
		alm(3'b100);
		rdchk(OFS_LOAD_I, 32'h0000_0384);
		samp(14'h0316);
		alm(3'b100);
		samp(14'h030C);
		alm(3'b000);
	endtask

	task automatic t_low();
		wr(OFS_LOW_THR, 32'h0000_01F4);
		samp(14'h0190);
		alm(3'b001);
		samp(14'h01FE);
		alm(3'b001);
		samp(14'h0208);
		alm(3'b000);
		rdchk(OFS_LOAD_I, 32'h0000_0208);
		wr(OFS_LOW_THR, 32'h0000_0000);
	endtask

	// Other outputs on must not count as the selected one being on
	task automatic t_leak();
		wr(OFS_LEAK_THR, 32'h0000_0064);
		output_on <= 4'hE;
		samp(14'h0096);
		alm(3'b010);
		rdchk(OFS_LEAK_I, 32'h0000_0096);
		rdchk(OFS_LOAD_I, 32'h0000_0208);
		samp(14'h0050);
		alm(3'b000);
		output_on <= 4'h1;
		samp(14'h0096);
		alm(3'b000);
		wr(OFS_LEAK_THR, 32'h0000_0000);
	endtask

	task automatic t_latch();
		wr(OFS_CTRL, 32'h0000_0111);
		samp(14'h0384);
		samp(14'h02BC);
		alm(3'b100);
		wr(OFS_ACK, 32'h0000_0000);
		alm(3'b100);
		wr(OFS_ACK, 32'h0000_0001);
		alm(3'b000);
		samp(14'h0384);
		wr(OFS_ACK, 32'h0000_0001);
		alm(3'b100);
		samp(14'h02BC);
		alm(3'b000);
		wr(OFS_CTRL, 32'h0000_0211);
		samp(14'h0384);
		wr(OFS_ACK, 32'h0000_0001);
		alm(3'b100);
		samp(14'h02BC);
		alm(3'b100);
		wr(OFS_ACK, 32'h0000_0001);
		alm(3'b000);
	endtask

	// Sticky status, mask and clear of the interrupt
	task automatic t_irq();
		wr(OFS_CTRL, 32'h0000_0011);
		wr(OFS_IRQ_CLR, 32'h0000_0007);
		wr(OFS_IRQ_EN, 32'h0000_0004);
		check({31'h0, irq}, 32'h0000_0000);
		samp(14'h0384);
		samp(14'h02BC);
		check({31'h0, irq}, 32'h0000_0001);
		rdchk(OFS_IRQ_STAT, 32'h0000_0004);
		wr(OFS_IRQ_EN, 32'h0000_0000);
		check({31'h0, irq}, 32'h0000_0000);
		wr(OFS_IRQ_EN, 32'h0000_0004);
		check({31'h0, irq}, 32'h0000_0001);
		wr(OFS_IRQ_CLR, 32'h0000_0004);
		check({31'h0, irq}, 32'h0000_0000);
		rdchk(OFS_IRQ_STAT, 32'h0000_0000);
		wr(OFS_HYST, 32'h0000_0007);
		rdchk(OFS_HYST, 32'h0000_0005);
		// Select 7 and latch code 3 are refused, old fields kept
		wr(OFS_CTRL, 32'h0000_0371);
		rdchk(OFS_CTRL, 32'h0000_0011);
		// Highest select follows the top heat output
		wr(OFS_CTRL, 32'h0000_0041);
		output_on <= 4'h8;
		samp(14'h00C8);
		rdchk(OFS_LOAD_I, 32'h0000_00C8);
	endtask

	// Main sequence
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_disabled();
		t_over();
		t_low();
		t_leak();
		t_latch();
		t_irq();
		print_verdict();
	end

	// Watchdog: the sequence needs well under a thousand cycles
	initial begin
		#200000;
		bad_count++;
		print_verdict();
	end
endmodule // tb_top
`default_nettype wire
